//--- fetx_map.vh
`ifndef FETX_MAP_VH
`define FETX_MAP_VH
// ==========================================================
// code-groups
`define FETX_CG_IDLE 5'h1f
`define FETX_CG_J 5'h18
`define FETX_CG_K 5'h11
`define FETX_CG_T 5'h0d
`define FETX_CG_R 5'h07
`define FETX_CG_HALT 5'h04
// ==========================================================
// framing and scrambler
`define FETX_BIT_LAST 3'h4
`define FETX_SCR_ZERO 11'h000
`define FETX_SCR_FILL 6'h2a
`define FETX_SCR_TAP_A 10
`define FETX_SCR_TAP_B 8
// ==========================================================
// mlt-3 phases
`define FETX_MLT_ZP 2'h0
`define FETX_MLT_PLUS 2'h1
`define FETX_MLT_ZM 2'h2
`define FETX_MLT_MINUS 2'h3
`endif

//--- fetx_code_map.v
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// nibble to 5-bit data code-group lookup
module fetx_code_map (
  input wire [3:0] nibble,
  output reg [4:0] code
);
  always @* begin
    case (nibble)
      4'h0: code = 5'h1e;
      4'h1: code = 5'h09;
      4'h2: code = 5'h14;
      4'h3: code = 5'h15;
      4'h4: code = 5'h0a;
      4'h5: code = 5'h0b;
      4'h6: code = 5'h0e;
      4'h7: code = 5'h0f;
      4'h8: code = 5'h12;
      4'h9: code = 5'h13;
      4'ha: code = 5'h16;
      4'hb: code = 5'h17;
      4'hc: code = 5'h1a;
      4'hd: code = 5'h1b;
      4'he: code = 5'h1c;
      default: code = 5'h1d;
    endcase
  end
endmodule
`default_nettype wire

//--- fetx_encoder.v
`include "fetx_map.vh"
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// 100 Mb/s transmit path: 4B/5B, scrambler, NRZI, MLT-3.
// SYS_CLK is the bit clock; a nibble is taken every fifth cycle.
module fetx_encoder (
  input wire SYS_CLK,
  input wire RST,
  input wire TX_EN,
  input wire TX_ER,
  input wire [3:0] TXD,
  input wire [4:0] PHY_ADDRESS_PINS,
  input wire SCR_BYPASS,
  input wire FIBER_MODE,
  output reg NIBBLE_TAKE,
  output reg TX_P,
  output reg TX_N,
  output reg [1:0] MLT_LOOPBACK,
  output reg NRZI_OUT
);
  localparam ST_IDLE = 5'h01;
  localparam ST_J = 5'h02;
  localparam ST_K = 5'h04;
  localparam ST_DATA = 5'h08;
  localparam ST_R = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [2:0] bit_cnt;
  reg [4:0] shift;
  reg [4:0] next_code;
  reg [10:0] lfsr;
  reg nrzi;
  reg [1:0] mlt;
  reg [1:0] next_mlt;
  reg take_now;
  reg seeded;
  wire [4:0] data_code;
  wire boundary;
  wire scr_bit;
  wire nrz_bit;
  wire next_nrzi;
  wire bypass;
  wire [10:0] seed;

  fetx_code_map u_map (
    .nibble(TXD),
    .code(data_code)
  );

  assign boundary = (bit_cnt == `FETX_BIT_LAST);

  // ==========================================================
  // framing state machine, advanced once per code-group
  always @* begin
    next_state = state;
    next_code = `FETX_CG_IDLE;
    take_now = 1'b0;
    case (state)
      ST_IDLE: begin
        if (TX_EN) begin
          // first preamble nibble consumed under J
          next_code = `FETX_CG_J;
          next_state = ST_K;
          take_now = 1'b1;
        end
      end
      ST_K: begin
        next_code = `FETX_CG_K;
        next_state = ST_DATA;
        take_now = 1'b1;
      end
      ST_DATA: begin
        if (!TX_EN) begin
          next_code = `FETX_CG_T;
          next_state = ST_R;
        end else begin
          take_now = 1'b1;
          // mac error mid-frame goes out as halt
          next_code = TX_ER ? `FETX_CG_HALT : data_code;
        end
      end
      ST_R: begin
        next_code = `FETX_CG_R;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= `FETX_CG_IDLE;
      NIBBLE_TAKE <= 1'b0;
    end else begin
      NIBBLE_TAKE <= 1'b0;
      if (boundary) begin
        bit_cnt <= 3'h0;
        state <= next_state;
        shift <= next_code;
        NIBBLE_TAKE <= take_now;
      end else begin
        bit_cnt <= bit_cnt + 3'h1;
        shift <= {shift[3:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // scrambler; seed padded so it is never all zero
  assign seed = {PHY_ADDRESS_PINS, `FETX_SCR_FILL};
  assign scr_bit = lfsr[`FETX_SCR_TAP_A] ^ lfsr[`FETX_SCR_TAP_B];
  assign bypass = SCR_BYPASS | FIBER_MODE;
  assign nrz_bit = bypass ? shift[4] : (shift[4] ^ scr_bit);

  always @(posedge SYS_CLK) begin
    if (RST) begin
      lfsr <= {5'h00, `FETX_SCR_FILL};
    end else if (!seeded || lfsr == `FETX_SCR_ZERO) begin
      // address seed loaded first cycle after release, and on lock-up
      lfsr <= seed;
    end else begin
      lfsr <= {lfsr[9:0], scr_bit};
    end
  end

  // reseed once out of reset; address pins taken after release
  always @(posedge SYS_CLK) begin
    if (RST) begin
      seeded <= 1'b0;
    end else begin
      seeded <= 1'b1;
    end
  end

  // ==========================================================
  // nrzi, always present, and mlt-3
  assign next_nrzi = nrzi ^ nrz_bit;

  always @* begin
    next_mlt = mlt;
    if (nrz_bit) begin
      case (mlt)
        `FETX_MLT_ZP: next_mlt = `FETX_MLT_PLUS;
        `FETX_MLT_PLUS: next_mlt = `FETX_MLT_ZM;
        `FETX_MLT_ZM: next_mlt = `FETX_MLT_MINUS;
        default: next_mlt = `FETX_MLT_ZP;
      endcase
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      nrzi <= 1'b0;
      mlt <= `FETX_MLT_ZP;
      NRZI_OUT <= 1'b0;
      MLT_LOOPBACK <= `FETX_MLT_ZP;
      TX_P <= 1'b0;
      TX_N <= 1'b0;
    end else begin
      nrzi <= next_nrzi;
      mlt <= next_mlt;
      NRZI_OUT <= next_nrzi;
      MLT_LOOPBACK <= next_mlt;
      if (FIBER_MODE) begin
        // fiber: plain nrzi on the positive leg, its complement on the negative leg
        TX_P <= next_nrzi;
        TX_N <= ~next_nrzi;
      end else begin
        TX_P <= (next_mlt == `FETX_MLT_PLUS);
        TX_N <= (next_mlt == `FETX_MLT_MINUS);
      end
    end
  end
endmodule
`default_nettype wire

//--- fetx_encoder_props.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// port checks
module fetx_encoder_props (
  input wire SYS_CLK,
  input wire RST,
  input wire TX_EN,
  input wire FIBER_MODE,
  input wire NIBBLE_TAKE,
  input wire TX_P,
  input wire TX_N,
  input wire [1:0] MLT_LOOPBACK,
  input wire NRZI_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_take_gap: assert property (NIBBLE_TAKE |=> !NIBBLE_TAKE [*4])
    else $error("take gap");
  a_take_en: assert property (NIBBLE_TAKE |-> $past(TX_EN))
    else $error("take idle");
  a_idle_quiet: assert property (!TX_EN [*6] |-> !NIBBLE_TAKE)
    else $error("idle take");
  a_pair_excl: assert property (!FIBER_MODE && !$past(FIBER_MODE) |-> !(TX_P && TX_N))
    else $error("pair both");
  a_fiber_comp: assert property (FIBER_MODE && $past(FIBER_MODE) && !$past(RST) |-> TX_P != TX_N)
    else $error("fiber pair");
  a_mlt_step: assert property ($changed(MLT_LOOPBACK) |-> MLT_LOOPBACK == $past(MLT_LOOPBACK) + 2'h1)
    else $error("mlt step");
  a_mlt_nrzi: assert property ($changed(MLT_LOOPBACK) |-> $changed(NRZI_OUT))
    else $error("mlt nrzi");
  a_rst_zero: assert property ($past(RST) |-> !NIBBLE_TAKE && !TX_P && !TX_N && !NRZI_OUT)
    else $error("reset out");
  cover property (NIBBLE_TAKE);
  cover property (TX_N && !FIBER_MODE);
  cover property (FIBER_MODE && TX_P);
endmodule
bind fetx_encoder fetx_encoder_props u_props (.*);
`default_nettype wire

//--- fetx_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// mii side: two preamble nibbles, then 0..f
module fetx_mac_model (
  input wire clk,
  input wire rst,
  input wire go,
  input wire take,
  output reg tx_en = 1'b0,
  output reg [3:0] txd = 4'h5
);
  reg [4:0] idx;
  // moves only after a take, so txd holds over the slot
  always @(posedge clk) begin
    if (rst || go) begin
      tx_en <= #1 go;
      txd <= #1 4'h5;
      idx <= 5'h00;
    end else if (take) begin
      idx <= idx + 5'h01;
      txd <= #1 (idx == 5'h00) ? 4'h5 : idx[3:0] - 4'h1;
      if (idx == 5'h11)
        tx_en <= #1 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb_fetx_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module tb_fetx_encoder;
  reg SYS_CLK = 0, RST = 1, TX_ER = 0, SCR_BYPASS = 1, FIBER_MODE = 0, go = 0, pn = 0;
  reg [4:0] PHY_ADDRESS_PINS = 5'h0b;
  reg [4:0] rows [0:15];
  reg [9:0] sr = 10'h000;
  integer failures = 0, samples_checked = 0, i, k;
  wire TX_EN, NIBBLE_TAKE, TX_P, TX_N, NRZI_OUT;
  wire [1:0] MLT_LOOPBACK;
  wire [3:0] TXD;
  fetx_encoder u_dut (.*);
  fetx_mac_model u_mac (.clk(SYS_CLK), .rst(RST), .go(go), .take(NIBBLE_TAKE),
    .tx_en(TX_EN), .txd(TXD));
  always #25 SYS_CLK = ~SYS_CLK;
  // ====
  // line bit recovery from nrzi transitions
  task bit_in;
    @(negedge SYS_CLK);
    sr = {sr[8:0], NRZI_OUT ^ pn};
    pn = NRZI_OUT;
  endtask
  task cmp(input [9:0] g, input [9:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    rows = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16,
      5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    repeat (16) @(posedge SYS_CLK);
    #1 RST = 0;
    @(negedge SYS_CLK);
    cmp({NIBBLE_TAKE, TX_P, TX_N, MLT_LOOPBACK, NRZI_OUT}, 10'h000);
    @(posedge SYS_CLK) #1 go = 1;
    @(posedge SYS_CLK) #1 go = 0;
    k = 0;
    while (sr !== 10'h311 && k < 300) begin
      bit_in;
      k = k + 1;
    end
    cmp(sr, 10'h311);
    for (i = 0; i < 16; i = i + 1) begin
      repeat (5) bit_in;
      cmp(sr[4:0], rows[i]);
    end
    repeat (10) bit_in;
    cmp(sr, {5'h0d, 5'h07});
    repeat (10) bit_in;
    cmp(sr, 10'h3ff);
    // second frame with mac error: data slots carry halt
    @(posedge SYS_CLK) #1 go = 1;
    TX_ER = 1;
    @(posedge SYS_CLK) #1 go = 0;
    k = 0;
    sr = 10'h000;
    while (sr !== 10'h311 && k < 300) begin
      bit_in;
      k = k + 1;
    end
    cmp(sr, 10'h311);
    repeat (5) bit_in;
    cmp(sr[4:0], 5'h04);
    repeat (100) bit_in;
    TX_ER = 0;
    cmp(sr, 10'h3ff);
    // scrambled idles must break the all-ones run
    @(posedge SYS_CLK) #1 SCR_BYPASS = 0;
    repeat (12) bit_in;
    cmp(sr === 10'h3ff, 10'h000);
    @(posedge SYS_CLK) #1 FIBER_MODE = 1;
    repeat (12) bit_in;
    cmp(sr, 10'h3ff);
    give_verdict;
  end
endmodule
`default_nettype wire
